// >>> design/risc_pkg.sv
// Shared constants and types of the reference input selection block.
// Assumes an 8-bit register view, each register on one 32-bit word.
package risc_pkg;

   // ----------------------------------------
   // Register indices (byte address = 4 x index)
   // ----------------------------------------
   localparam int unsigned ADDR_W = 10;
   localparam logic [7:0] IDX_EDGE = 8'h31;
   localparam logic [7:0] IDX_SEL = 8'h32;
   localparam logic [7:0] IDX_CTL = 8'h33;
   localparam logic [7:0] IDX_PDIV = 8'h34;
   localparam logic [7:0] IDX_STAT = 8'h35;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int EDGE1_LSB = 2;
   localparam int EDGE0_LSB = 0;
   localparam int SECM_LSB = 6;
   localparam int PRIM_LSB = 4;
   localparam int SELB_LSB = 2;
   localparam int SELA_LSB = 0;
   localparam int SKIP_BIT = 7;
   localparam int KEEP_BIT = 2;
   localparam int SGAIN_BIT = 1;
   localparam int PGAIN_BIT = 0;
   localparam int PDIV_LSB = 0;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [1:0] EDGE_RST = 2'h0;
   localparam logic [1:0] SECM_RST = 2'h2;
   localparam logic [1:0] PRIM_RST = 2'h1;
   localparam logic [1:0] SELB_RST = 2'h1;
   localparam logic [1:0] SELA_RST = 2'h1;
   localparam logic SKIP_RST = 1'b0;
   localparam logic KEEP_RST = 1'b0;
   localparam logic SGAIN_RST = 1'b1;
   localparam logic PGAIN_RST = 1'b1;
   localparam logic [2:0] PDIV_RST = 3'h0;

   // ----------------------------------------
   // Codes
   // ----------------------------------------
   localparam logic [1:0] EDGE_FAST = 2'h0;
   localparam logic [1:0] EDGE_SLOW = 2'h2;

   typedef enum logic [1:0] {
      SRC_AUTO = 2'h0,
      SRC_PIN = 2'h1,
      SRC_PRI = 2'h2,
      SRC_SEC = 2'h3
   } risc_src_mode_t;

   typedef enum logic [1:0] {
      BUF_SE = 2'h0,
      BUF_DIFF = 2'h1,
      BUF_XTAL = 2'h2,
      BUF_OFF = 2'h3
   } risc_buf_mode_t;

   typedef enum logic [1:0] {
      PIN_LOW = 2'h0,
      PIN_MID = 2'h1,
      PIN_HIGH = 2'h2
   } risc_pin_lvl_t;

   typedef enum logic [1:0] {
      MUX_RUN = 2'b01,
      MUX_DRAIN = 2'b10
   } risc_mux_st_t;

   typedef struct packed {
      logic [1:0] edge1;
      logic [1:0] edge0;
      risc_buf_mode_t sec_mode;
      risc_buf_mode_t pri_mode;
      risc_src_mode_t synth_b;
      risc_src_mode_t synth_a;
      logic skip;
      logic keep;
      logic sgain;
      logic pgain;
      logic [2:0] pdiv;
   } risc_cfg_t;

endpackage : risc_pkg

// >>> design/risc_ref_path.sv
// One synthesizer's reference selector with a glitch-free switch.
// Assumes reference inputs are sampled levels in the system clock domain.
`timescale 1ns/10ps
module risc_ref_path #(
   parameter bit PIN_LOW_PRI = 1'b1
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Selection
   input wire risc_pkg::risc_src_mode_t mode_in,
   input wire risc_pkg::risc_pin_lvl_t pin_lvl_in,
   input wire logic skip_in,
   input wire logic pri_ok_in,
   input wire logic sec_ok_in,
   // Sources
   input wire logic pri_ref_in,
   input wire logic sec_ref_in,
   // Result
   output logic ref_out,
   output logic use_sec_out
);

   typedef struct packed {
      risc_pkg::risc_mux_st_t fsm;
      logic cur_sec;
      logic out;
   } risc_path_st_t;

   risc_path_st_t st_reg;
   risc_path_st_t st_next;
   logic want_sec;
   logic auto_sec;
   logic cur_src;
   logic tgt_src;

   // ----------------------------------------
   // Source choice
   // ----------------------------------------
   always_comb begin
      auto_sec = !pri_ok_in && sec_ok_in;
      unique case (mode_in)
         risc_pkg::SRC_AUTO: want_sec = auto_sec;
         risc_pkg::SRC_PIN: begin
            if (PIN_LOW_PRI) begin
               want_sec = (pin_lvl_in == risc_pkg::PIN_LOW) ? 1'b0 : auto_sec;
            end else begin
               want_sec = (pin_lvl_in == risc_pkg::PIN_HIGH) ? auto_sec : 1'b1;
            end
         end
         risc_pkg::SRC_PRI: want_sec = 1'b0;
         risc_pkg::SRC_SEC: want_sec = 1'b1;
      endcase
   end

   // ----------------------------------------
   // Glitch-free switch
   // ----------------------------------------
   // Old source must go low, then output stays low until the new one is low
   always_comb begin
      st_next = st_reg;
      cur_src = st_reg.cur_sec ? sec_ref_in : pri_ref_in;
      tgt_src = want_sec ? sec_ref_in : pri_ref_in;
      unique case (st_reg.fsm)
         risc_pkg::MUX_RUN: begin
            st_next.out = cur_src;
            if (want_sec != st_reg.cur_sec) begin
               if (skip_in) begin
                  st_next.cur_sec = want_sec;
                  st_next.out = tgt_src;
               end else if (!cur_src) begin
                  st_next.fsm = risc_pkg::MUX_DRAIN;
                  st_next.out = 1'b0;
               end
            end
         end
         risc_pkg::MUX_DRAIN: begin
            st_next.out = 1'b0;
            // Bypass ends the wait at once; output stays low one more cycle
            if (skip_in || !tgt_src) begin
               st_next.cur_sec = want_sec;
               st_next.fsm = risc_pkg::MUX_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_reg <= '{fsm: risc_pkg::MUX_RUN, cur_sec: 1'b0, out: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign ref_out = st_reg.out;
   assign use_sec_out = st_reg.cur_sec;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   AST_PIN_B_SEC: assert property (
      (!PIN_LOW_PRI && mode_in == risc_pkg::SRC_PIN && pin_lvl_in != risc_pkg::PIN_HIGH
       && skip_in) [*2] |-> use_sec_out)
      else $error("pin low or mid did not pick secondary");
   AST_PIN_A_PRI: assert property (
      (PIN_LOW_PRI && mode_in == risc_pkg::SRC_PIN && pin_lvl_in == risc_pkg::PIN_LOW
       && skip_in) [*2] |-> !use_sec_out)
      else $error("pin low did not pick primary");
   AST_DRAIN_LOW: assert property (
      st_reg.fsm == risc_pkg::MUX_DRAIN |=> !ref_out)
      else $error("output not held low while switching");
   AST_SKIP_NOW: assert property (
      skip_in && want_sec != use_sec_out |=> use_sec_out == $past(want_sec))
      else $error("bypassed switch did not happen at once");
   CVR_DRAIN: cover property (st_reg.fsm == risc_pkg::MUX_DRAIN ##[1:50] st_reg.fsm ==
      risc_pkg::MUX_RUN);

endmodule : risc_ref_path

// >>> design/risc_top.sv
// Reference input selection and configuration, Avalon-MM register slave.
// Assumes reference inputs and the choice pin are synchronous to clk_sys_in.
`timescale 1ns/10ps
module risc_top #(
   parameter int unsigned LOS_CYCLES = 64
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   // Avalon-MM slave
   input wire logic [risc_pkg::ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Reference sources and choice pin
   input wire logic pri_ref_in,
   input wire logic sec_ref_in,
   input wire risc_pkg::risc_pin_lvl_t ref_choice_pin_in,
   // Analog controls
   output logic [1:0] status_pin1_edge_rate_out,
   output logic [1:0] status_pin0_edge_rate_out,
   output logic [1:0] primary_buffer_mode_out,
   output logic [1:0] secondary_buffer_mode_out,
   output logic pri_buf_en_out,
   output logic sec_buf_en_out,
   output logic primary_buffer_gain_out,
   output logic secondary_buffer_gain_out,
   // Synthesizer references
   output logic synth_a_ref_out,
   output logic synth_b_ref_out
);

   localparam int LOS_W = $clog2(LOS_CYCLES + 1);
   localparam logic [LOS_W-1:0] LOS_MAX = LOS_W'(LOS_CYCLES);

   typedef struct packed {
      risc_pkg::risc_cfg_t cfg;
      logic ack;
      logic [7:0] rdata;
      logic [1:0][LOS_W-1:0] los_cnt;
      logic [1:0] src_prev;
      logic [1:0] src_ok;
      logic pri_en;
      logic sec_en;
      logic xtal_off;
      logic [1:0] use_sec_q;
      logic a_prev;
      logic [2:0] div_cnt;
      logic a_out;
      logic b_out;
   } risc_top_st_t;

   localparam risc_pkg::risc_cfg_t CFG_RST = '{
      edge1: risc_pkg::EDGE_RST,
      edge0: risc_pkg::EDGE_RST,
      sec_mode: risc_pkg::risc_buf_mode_t'(risc_pkg::SECM_RST),
      pri_mode: risc_pkg::risc_buf_mode_t'(risc_pkg::PRIM_RST),
      synth_b: risc_pkg::risc_src_mode_t'(risc_pkg::SELB_RST),
      synth_a: risc_pkg::risc_src_mode_t'(risc_pkg::SELA_RST),
      skip: risc_pkg::SKIP_RST,
      keep: risc_pkg::KEEP_RST,
      sgain: risc_pkg::SGAIN_RST,
      pgain: risc_pkg::PGAIN_RST,
      pdiv: risc_pkg::PDIV_RST
   };

   logic [1:0] rst_sync;
   logic rst_n;
   risc_top_st_t st_reg;
   risc_top_st_t st_next;
   logic [1:0] ref_w;
   logic [1:0] use_sec_w;
   logic [1:0] src_w;
   logic [7:0] idx;
   logic wr_go;
   logic a_rise;
   logic back_pri;
   logic xtal_set;
   logic xtal_clr;

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // ----------------------------------------
   // Register readback
   // ----------------------------------------
   // Reserved positions stay zero because only named fields are placed
   function automatic logic [7:0] rd_byte(input logic [7:0] i, input risc_top_st_t s);
      logic [7:0] v;
      v = 8'h00;
      if (i == risc_pkg::IDX_EDGE) begin
         v[risc_pkg::EDGE1_LSB +: 2] = s.cfg.edge1;
         v[risc_pkg::EDGE0_LSB +: 2] = s.cfg.edge0;
      end else if (i == risc_pkg::IDX_SEL) begin
         v[risc_pkg::SECM_LSB +: 2] = s.cfg.sec_mode;
         v[risc_pkg::PRIM_LSB +: 2] = s.cfg.pri_mode;
         v[risc_pkg::SELB_LSB +: 2] = s.cfg.synth_b;
         v[risc_pkg::SELA_LSB +: 2] = s.cfg.synth_a;
      end else if (i == risc_pkg::IDX_CTL) begin
         v[risc_pkg::SKIP_BIT] = s.cfg.skip;
         v[risc_pkg::KEEP_BIT] = s.cfg.keep;
         v[risc_pkg::SGAIN_BIT] = s.cfg.sgain;
         v[risc_pkg::PGAIN_BIT] = s.cfg.pgain;
      end else if (i == risc_pkg::IDX_PDIV) begin
         v[risc_pkg::PDIV_LSB +: 3] = s.cfg.pdiv;
      end else if (i == risc_pkg::IDX_STAT) begin
         v[4:0] = {s.xtal_off, s.use_sec_q, s.src_ok};
      end
      return v;
   endfunction : rd_byte

   // ----------------------------------------
   // Per-synthesizer selectors
   // ----------------------------------------
   // A source stuck high never lets the old path drain; use the skip bit then
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_path
         risc_ref_path #(
            .PIN_LOW_PRI(g == 0)
         ) u_path (
            .clk_sys_in(clk_sys_in),
            .rst_n_in(rst_n),
            .mode_in((g == 0) ? st_reg.cfg.synth_a : st_reg.cfg.synth_b),
            .pin_lvl_in(ref_choice_pin_in),
            .skip_in(st_reg.cfg.skip),
            .pri_ok_in(st_reg.src_ok[0]),
            .sec_ok_in(st_reg.src_ok[1]),
            .pri_ref_in(pri_ref_in),
            .sec_ref_in(sec_ref_in),
            .ref_out(ref_w[g]),
            .use_sec_out(use_sec_w[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      idx = avs_address_in[9:2];
      src_w = {sec_ref_in, pri_ref_in};
      // One wait cycle; write lands when waitrequest is seen low
      st_next.ack = (avs_read_in || avs_write_in) && !st_reg.ack;
      if (avs_read_in && !st_reg.ack) begin
         st_next.rdata = rd_byte(idx, st_reg);
      end
      wr_go = avs_write_in && st_reg.ack && avs_byteenable_in[0];
      if (wr_go) begin
         if (idx == risc_pkg::IDX_EDGE) begin
            st_next.cfg.edge1 = avs_writedata_in[risc_pkg::EDGE1_LSB +: 2];
            st_next.cfg.edge0 = avs_writedata_in[risc_pkg::EDGE0_LSB +: 2];
         end else if (idx == risc_pkg::IDX_SEL) begin
            st_next.cfg.sec_mode = risc_pkg::risc_buf_mode_t'(
               avs_writedata_in[risc_pkg::SECM_LSB +: 2]);
            st_next.cfg.pri_mode = risc_pkg::risc_buf_mode_t'(
               avs_writedata_in[risc_pkg::PRIM_LSB +: 2]);
            st_next.cfg.synth_b = risc_pkg::risc_src_mode_t'(
               avs_writedata_in[risc_pkg::SELB_LSB +: 2]);
            st_next.cfg.synth_a = risc_pkg::risc_src_mode_t'(
               avs_writedata_in[risc_pkg::SELA_LSB +: 2]);
         end else if (idx == risc_pkg::IDX_CTL) begin
            st_next.cfg.skip = avs_writedata_in[risc_pkg::SKIP_BIT];
            st_next.cfg.keep = avs_writedata_in[risc_pkg::KEEP_BIT];
            st_next.cfg.sgain = avs_writedata_in[risc_pkg::SGAIN_BIT];
            st_next.cfg.pgain = avs_writedata_in[risc_pkg::PGAIN_BIT];
         end else if (idx == risc_pkg::IDX_PDIV) begin
            st_next.cfg.pdiv = avs_writedata_in[risc_pkg::PDIV_LSB +: 3];
         end
      end

      // Activity watch; a disabled buffer never counts as present
      for (int i = 0; i < 2; i++) begin
         st_next.src_prev[i] = src_w[i];
         if (src_w[i] && !st_reg.src_prev[i]) begin
            st_next.los_cnt[i] = '0;
         end else if (st_reg.los_cnt[i] != LOS_MAX) begin
            st_next.los_cnt[i] = st_reg.los_cnt[i] + LOS_W'(1);
         end
      end
      st_next.src_ok[0] = st_reg.pri_en && (st_reg.los_cnt[0] < LOS_MAX);
      st_next.src_ok[1] = st_reg.sec_en && (st_reg.los_cnt[1] < LOS_MAX);

      // Buffer enables
      st_next.pri_en = !st_reg.cfg.pri_mode[1];
      st_next.sec_en = (st_reg.cfg.sec_mode != risc_pkg::BUF_OFF) && !st_reg.xtal_off;

      // Crystal shut-off after return to primary; set wins over clear
      st_next.use_sec_q = use_sec_w;
      back_pri = |(st_reg.use_sec_q & ~use_sec_w) && !(|use_sec_w);
      xtal_set = back_pri && st_reg.cfg.sec_mode == risc_pkg::BUF_XTAL && !st_reg.cfg.keep;
      xtal_clr = st_reg.cfg.keep || st_reg.cfg.sec_mode != risc_pkg::BUF_XTAL || |use_sec_w;
      if (xtal_set) begin
         st_next.xtal_off = 1'b1;
      end else if (xtal_clr) begin
         st_next.xtal_off = 1'b0;
      end

      // Synth A predivider, counted on reference rising edges
      a_rise = ref_w[0] && !st_reg.a_prev;
      st_next.a_prev = ref_w[0];
      if (st_reg.cfg.pdiv == 3'h0) begin
         st_next.div_cnt = 3'h0;
         st_next.a_out = ref_w[0];
      end else begin
         if (a_rise) begin
            st_next.div_cnt = (st_reg.div_cnt >= st_reg.cfg.pdiv) ? 3'h0 :
               st_reg.div_cnt + 3'h1;
         end
         st_next.a_out = st_next.div_cnt <= (st_reg.cfg.pdiv >> 1);
      end
      st_next.b_out = ref_w[1];
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{cfg: CFG_RST, los_cnt: {LOS_MAX, LOS_MAX}, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign avs_readdata_out = {24'h000000, st_reg.rdata};
   assign avs_waitrequest_out = !st_reg.ack;
   assign status_pin1_edge_rate_out = st_reg.cfg.edge1;
   assign status_pin0_edge_rate_out = st_reg.cfg.edge0;
   assign primary_buffer_mode_out = st_reg.cfg.pri_mode;
   assign secondary_buffer_mode_out = st_reg.cfg.sec_mode;
   assign pri_buf_en_out = st_reg.pri_en;
   assign sec_buf_en_out = st_reg.sec_en;
   assign primary_buffer_gain_out = st_reg.cfg.pgain;
   assign secondary_buffer_gain_out = st_reg.cfg.sgain;
   assign synth_a_ref_out = st_reg.a_out;
   assign synth_b_ref_out = st_reg.b_out;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n);

   AST_EDGE1_WR: assert property (
      wr_go && idx == risc_pkg::IDX_EDGE |=> status_pin1_edge_rate_out ==
      $past(avs_writedata_in[3:2]))
      else $error("pin one edge rate not stored");
   AST_EDGE0_WR: assert property (
      wr_go && idx == risc_pkg::IDX_EDGE |=> status_pin0_edge_rate_out ==
      $past(avs_writedata_in[1:0]))
      else $error("pin zero edge rate not stored");
   AST_SEC_OFF: assert property (
      (st_reg.cfg.sec_mode == risc_pkg::BUF_OFF) [*2] |-> !sec_buf_en_out)
      else $error("secondary buffer on while disabled");
   AST_PRI_EN: assert property (
      $stable(st_reg.cfg.pri_mode) |=> pri_buf_en_out == ($past(st_reg.cfg.pri_mode) <= 2'h1))
      else $error("primary enable disagrees with mode");
   AST_B_FORCE: assert property (
      (st_reg.cfg.synth_b == risc_pkg::SRC_SEC && st_reg.cfg.skip) [*2] |-> use_sec_w[1])
      else $error("synth B not forced to secondary");
   AST_A_FORCE: assert property (
      (st_reg.cfg.synth_a == risc_pkg::SRC_PRI && st_reg.cfg.skip) [*2] |-> !use_sec_w[0])
      else $error("synth A not forced to primary");
   AST_XTAL_OFF: assert property (
      xtal_set |-> ##2 !sec_buf_en_out)
      else $error("crystal buffer left on after return");
   AST_XTAL_KEEP: assert property (
      st_reg.cfg.keep [*2] |-> !st_reg.xtal_off)
      else $error("crystal buffer shut while keep set");
   AST_GAINS: assert property (
      wr_go && idx == risc_pkg::IDX_CTL |=> secondary_buffer_gain_out ==
      $past(avs_writedata_in[1]))
      else $error("secondary gain not stored");
   AST_PGAIN: assert property (
      wr_go && idx == risc_pkg::IDX_CTL |=> primary_buffer_gain_out ==
      $past(avs_writedata_in[0]))
      else $error("primary gain not stored");
   AST_DIV_WRAP: assert property (
      $stable(st_reg.cfg.pdiv) && st_reg.cfg.pdiv != 3'h0 && a_rise &&
      st_reg.div_cnt == st_reg.cfg.pdiv |=> st_reg.div_cnt == 3'h0)
      else $error("predivider did not wrap at code");
   AST_RSVD_ZERO: assert property (
      !avs_waitrequest_out && avs_read_in && idx == risc_pkg::IDX_CTL |->
      avs_readdata_out[6:3] == 4'h0 && avs_readdata_out[31:8] == 24'h000000)
      else $error("reserved bits read nonzero");
   AST_MODE_WR: assert property (
      wr_go && idx == risc_pkg::IDX_SEL |=>
      secondary_buffer_mode_out == $past(avs_writedata_in[7:6]) &&
      primary_buffer_mode_out == $past(avs_writedata_in[5:4]))
      else $error("buffer modes not stored");
   AST_SEL_WR: assert property (
      wr_go && idx == risc_pkg::IDX_SEL |=>
      st_reg.cfg.synth_b == $past(avs_writedata_in[3:2]) &&
      st_reg.cfg.synth_a == $past(avs_writedata_in[1:0]))
      else $error("reference selections not stored");
   AST_PDIV_WR: assert property (
      wr_go && idx == risc_pkg::IDX_PDIV |=> st_reg.cfg.pdiv == $past(avs_writedata_in[2:0]))
      else $error("predivide code not stored");
   AST_BE_OFF: assert property (
      avs_write_in && !avs_byteenable_in[0] |=> $stable(st_reg.cfg))
      else $error("write without low byte lane changed a field");
   AST_ONE_WAIT: assert property (
      (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("request not answered after one wait cycle");

   CVR_A_TO_SEC: cover property (!use_sec_w[0] ##1 use_sec_w[0]);
   CVR_XTAL: cover property ($rose(st_reg.xtal_off));
   CVR_DIV8: cover property (st_reg.cfg.pdiv == 3'h7 && $rose(synth_a_ref_out));
   CVR_FALLBACK: cover property ($fell(st_reg.src_ok[0]) ##[1:40] use_sec_w[0]);

endmodule : risc_top

// >>> verif/risc_ref_src.sv
// Model of the two reference sources that feed the block.
// Assumes the bench clock; periods counted in clk_sys_in cycles.
`timescale 1ns/10ps
module risc_ref_src (
   // Clock
   input wire logic clk_sys_in,
   // Source enables
   input wire logic pri_run_in,
   input wire logic sec_run_in,
   // Reference levels
   output logic pri_ref_out,
   output logic sec_ref_out
);
   logic [3:0] cnt_reg = 4'h0;
   // Stopped source sits low, as a dead oscillator would
   always @(posedge clk_sys_in) begin
      cnt_reg <= cnt_reg + 4'h1;
      pri_ref_out <= pri_run_in & cnt_reg[2];
      sec_ref_out <= sec_run_in & cnt_reg[3];
   end
endmodule : risc_ref_src

// >>> verif/tb_risc_top.sv
// Self-checking bench for the reference selection block.
// Assumes risc_ref_src sources: primary period 8, secondary 16.
`timescale 1ns/10ps
module tb_risc_top;
   logic clk_sys_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [9:0] avs_address_in = 10'h000;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic [3:0] be = 4'hf;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic pri_ref_in, sec_ref_in, pri_buf_en_out, sec_buf_en_out;
   logic primary_buffer_gain_out, secondary_buffer_gain_out;
   logic synth_a_ref_out, synth_b_ref_out;
   logic [1:0] status_pin1_edge_rate_out, status_pin0_edge_rate_out;
   logic [1:0] primary_buffer_mode_out, secondary_buffer_mode_out;
   risc_pkg::risc_pin_lvl_t ref_choice_pin_in = risc_pkg::PIN_LOW;
   logic pri_run = 1'b1;
   logic [31:0] rd;
   logic [7:0] w[5];
   int p, error_cnt = 0, num_checks = 0;
   logic [7:0] ridx[5] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h40};
   logic [7:0] rval[5] = '{8'h00, 8'h95, 8'h03, 8'h00, 8'h00};
   logic [7:0] rmsk[5] = '{8'h0f, 8'hff, 8'h87, 8'h07, 8'h00};
   logic [7:0] tsel[4] = '{8'h9f, 8'h95, 8'h95, 8'h95};
   logic [1:0] tpin[4] = '{2'h0, 2'h0, 2'h1, 2'h2};
   int tpa[4] = '{16, 8, 8, 8};
   int tpb[4] = '{16, 16, 16, 8};
   logic [7:0] pdv[4] = '{8'h00, 8'h01, 8'h02, 8'h07};

   risc_top #(.LOS_CYCLES(16)) u_dut (.clk_sys_in, .nrst_in, .avs_address_in,
      .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in(be),
      .avs_readdata_out, .avs_waitrequest_out, .pri_ref_in, .sec_ref_in,
      .ref_choice_pin_in, .status_pin1_edge_rate_out, .status_pin0_edge_rate_out,
      .primary_buffer_mode_out, .secondary_buffer_mode_out, .pri_buf_en_out,
      .sec_buf_en_out, .primary_buffer_gain_out, .secondary_buffer_gain_out,
      .synth_a_ref_out, .synth_b_ref_out);
   risc_ref_src u_src (.clk_sys_in, .pri_run_in(pri_run), .sec_run_in(1'b1),
      .pri_ref_out(pri_ref_in), .sec_ref_out(sec_ref_in));

   initial forever #2 clk_sys_in = ~clk_sys_in;

   // ----------------------------------------
   // Bus, compare and measurement tasks
   // ----------------------------------------
   task automatic conclude;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      num_checks++;
      if (got !== ex) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk

   // Held until waitrequest is seen low; bounded so a dead slave ends the run
   task automatic bus(input bit wr, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      avs_address_in <= {idx, 2'h0};
      avs_writedata_in <= {24'h0, wd};
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 50);
      rd = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      @(posedge clk_sys_in);
      if (n >= 50) begin
         error_cnt++;
         conclude();
      end
   endtask : bus

   task automatic per(input bit b);
      int t, r1, k;
      logic v, pv;
      pv = 1'b1;
      k = 0;
      r1 = 0;
      p = 0;
      for (t = 0; t < 400 && k < 3; t++) begin
         @(posedge clk_sys_in);
         v = b ? synth_b_ref_out : synth_a_ref_out;
         if (v === 1'b1 && pv === 1'b0) begin
            k++;
            if (k == 3) p = t - r1;
            r1 = t;
         end
         pv = v;
      end
   endtask : per

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(70));
      repeat (6) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      foreach (ridx[i]) begin
         bus(0, ridx[i], 8'h00);
         chk("reset", {24'h0, rval[i]}, rd);
      end
      be <= 4'he;
      bus(1, 8'h31, 8'h0a);
      be <= 4'hf;
      bus(0, 8'h31, 8'h00);
      chk("be_off", 32'h0, rd);
      repeat (8) begin
         foreach (ridx[i]) begin
            w[i] = 8'($urandom);
            bus(1, ridx[i], w[i]);
            bus(0, ridx[i], 8'h00);
            chk("readback", {24'h0, w[i] & rmsk[i]}, rd);
         end
         chk("edge", 32'(w[0][3:0]), 32'({status_pin1_edge_rate_out,
            status_pin0_edge_rate_out}));
         chk("modes", 32'(w[1][7:4]), 32'({secondary_buffer_mode_out,
            primary_buffer_mode_out}));
         chk("pri_en", 32'(w[1][5:4] < 2'h2), 32'(pri_buf_en_out));
         chk("gain", 32'(w[2][1:0]), 32'({secondary_buffer_gain_out,
            primary_buffer_gain_out}));
      end
      // Bypassed switch, both synthesizers forced to primary
      bus(1, 8'h32, 8'h9a);
      bus(1, 8'h33, 8'h83);
      foreach (pdv[i]) begin
         bus(1, 8'h34, pdv[i]);
         repeat (40) @(posedge clk_sys_in);
         per(0);
         chk("predivide", 32'(8 * (pdv[i] + 1)), 32'(p));
      end
      bus(1, 8'h34, 8'h00);
      bus(1, 8'h33, 8'h03);
      foreach (tsel[i]) begin
         ref_choice_pin_in <= risc_pkg::risc_pin_lvl_t'(tpin[i]);
         bus(1, 8'h32, tsel[i]);
         repeat (60) @(posedge clk_sys_in);
         per(0);
         chk("synth_a", 32'(tpa[i]), 32'(p));
         per(1);
         chk("synth_b", 32'(tpb[i]), 32'(p));
      end
      for (int k = 0; k < 2; k++) begin
         bus(1, 8'h33, {5'h00, k[0], 2'h3});
         ref_choice_pin_in <= risc_pkg::PIN_LOW;
         repeat (60) @(posedge clk_sys_in);
         ref_choice_pin_in <= risc_pkg::PIN_HIGH;
         repeat (60) @(posedge clk_sys_in);
         chk("sec_en", 32'(k), 32'(sec_buf_en_out));
      end
      // Primary dies: automatic mode must fall back to secondary
      bus(1, 8'h32, 8'h90);
      pri_run <= 1'b0;
      repeat (60) @(posedge clk_sys_in);
      per(0);
      chk("fallback", 32'd16, 32'(p));
      bus(0, 8'h35, 8'h00);
      chk("status", 32'h0e, rd);
      conclude();
   end
endmodule : tb_risc_top
